// [design/lrx_exec.v]
// lrx_exec.v: decode and execute of store, load literal, idle, option load, return literal
// assumes: one opcode per enabled instruction cycle, stack pushed by the call logic outside
`timescale 1ns/1ps
`include "lrx_defs.vh"
module lrx_exec (
  input wire CLK_SYS,
  input wire RST_N,
  input wire INSTR_EN,
  input wire [`LRX_OP_W-1:0] OPCODE,
  input wire CALL_PUSH,
  input wire [`LRX_PC_W-1:0] CALL_ADDR,
  input wire [`LRX_PC_W-1:0] PC_IN,
  output reg [`LRX_DATA_W-1:0] ACC,
  output reg [`LRX_DATA_W-1:0] OPTION_REG,
  output reg FILE_WE,
  output reg [`LRX_FADDR_W-1:0] FILE_ADDR,
  output reg [`LRX_DATA_W-1:0] FILE_WDATA,
  output reg PC_LOAD,
  output reg [`LRX_PC_W-1:0] PC_NEW,
  output reg FLUSH,
  output reg [2:0] STATE
);
  localparam ST_RUN = 3'b001;
  localparam ST_POP = 3'b010;
  localparam ST_FLUSH = 3'b100;
  // ==========================================
  // opcode classes
  function is_literal_load;
    input [`LRX_OP_W-1:0] op;
    begin
      is_literal_load = (op[`LRX_TOP_HI:`LRX_TOP_LO] == `LRX_TOP_LOAD_LIT) ||
                        (op[`LRX_TOP_HI:`LRX_TOP_LO] == `LRX_TOP_RET_LIT);
    end
  endfunction
  wire load_literal_instr = INSTR_EN &&
    (OPCODE[`LRX_TOP_HI:`LRX_TOP_LO] == `LRX_TOP_LOAD_LIT);
  wire return_literal_instr = INSTR_EN &&
    (OPCODE[`LRX_TOP_HI:`LRX_TOP_LO] == `LRX_TOP_RET_LIT);
  wire store_acc_to_file_instr = INSTR_EN &&
    (OPCODE[`LRX_STORE_HI:`LRX_STORE_LO] == `LRX_STORE_PATTERN);
  wire option_instr = INSTR_EN && (OPCODE == `LRX_OPT_LOAD_OP);
  wire idle_instr = INSTR_EN && (OPCODE == `LRX_IDLE_OP);
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  wire [`LRX_PC_W-1:0] stack_top_entry;
  wire running = (state_r == ST_RUN);
  // return taken: pop now, flushed cycle on next enabled cycle
  wire pop_now = running && return_literal_instr;
  wire flush_now = (state_r == ST_POP) && INSTR_EN;
  // address popped, held for the flushed cycle
  reg [`LRX_PC_W-1:0] ret_addr_r;
  reg file_we_nxt;
  reg [`LRX_FADDR_W-1:0] file_addr_nxt;
  reg [`LRX_DATA_W-1:0] file_wdata_nxt;
  // ==========================================
  // return stack
  lrx_ret_stack u_stack (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .push(CALL_PUSH),
    .push_addr(CALL_ADDR),
    .pop(pop_now),
    .stack_top_entry(stack_top_entry)
  );
  // ==========================================
  // sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (return_literal_instr) begin
          state_nxt = ST_POP;
        end
      end
      ST_POP: begin
        if (INSTR_EN) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end
  // ==========================================
  // state register
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_RUN;
      STATE <= ST_RUN;
    end else begin
      state_r <= state_nxt;
      STATE <= state_nxt;
    end
  end
  // ==========================================
  // accumulator
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ACC <= `LRX_ACC_RST;
    end else if (running && INSTR_EN && is_literal_load(OPCODE)) begin
      // status flags untouched
      ACC <= OPCODE[`LRX_DATA_W-1:0];
    end
  end
  // ==========================================
  // option register
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      OPTION_REG <= `LRX_OPT_RST;
    end else if (running && option_instr) begin
      OPTION_REG <= ACC;
    end
  end
  // ==========================================
  // file write port, next values
  always @* begin
    file_we_nxt = 1'b0;
    file_addr_nxt = FILE_ADDR;
    file_wdata_nxt = FILE_WDATA;
    if (running && store_acc_to_file_instr) begin
      file_we_nxt = 1'b1;
      file_addr_nxt = OPCODE[`LRX_FADDR_W-1:0];
      file_wdata_nxt = ACC;
    end
  end
  // ==========================================
  // file write port registers
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      FILE_WE <= 1'b0;
      FILE_ADDR <= {`LRX_FADDR_W{1'b0}};
      FILE_WDATA <= `LRX_ACC_RST;
    end else begin
      FILE_WE <= file_we_nxt;
      FILE_ADDR <= file_addr_nxt;
      FILE_WDATA <= file_wdata_nxt;
    end
  end
  // ==========================================
  // return address capture
  // stack top still shows the old entry at the pop edge
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ret_addr_r <= {`LRX_PC_W{1'b0}};
    end else if (pop_now) begin
      ret_addr_r <= stack_top_entry;
    end
  end
  // ==========================================
  // program counter load and flush
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      PC_LOAD <= 1'b0;
      PC_NEW <= `LRX_PC_RST;
      FLUSH <= 1'b0;
    end else begin
      // only on the enabled flushed cycle, one pulse
      PC_LOAD <= flush_now;
      FLUSH <= flush_now;
      if (flush_now) begin
        PC_NEW <= ret_addr_r;
      end else if (running && idle_instr) begin
        PC_NEW <= PC_IN;
      end
    end
  end
endmodule // lrx_exec

// [design/lrx_defs.vh]
// lrx_defs.vh: opcode fields, encodings and reset values of the literal/return executor
// assumes: included by design files by bare name
`ifndef LRX_DEFS_VH
`define LRX_DEFS_VH
// ==========================================
// opcode fields
`define LRX_OP_W 12
`define LRX_DATA_W 8
`define LRX_PC_W 11
`define LRX_FADDR_W 5
`define LRX_TOP_HI 11
`define LRX_TOP_LO 8
`define LRX_STORE_HI 11
`define LRX_STORE_LO 5
// ==========================================
// encodings
`define LRX_TOP_LOAD_LIT 4'hC
`define LRX_TOP_RET_LIT 4'h8
`define LRX_STORE_PATTERN 7'h01
`define LRX_OPT_LOAD_OP 12'h002
`define LRX_IDLE_OP 12'h000
// ==========================================
// stack and reset values
`define LRX_STACK_DEPTH 2
`define LRX_ACC_RST 8'h00
`define LRX_OPT_RST 8'hFF
`define LRX_PC_RST 11'h7FF
`endif

// [design/lrx_ret_stack.v]
// lrx_ret_stack.v: two-entry hardware return stack, registered top read
// assumes: one clock, push and pop never in the same cycle
`timescale 1ns/1ps
`include "lrx_defs.vh"
module lrx_ret_stack (
  input wire clk,
  input wire rst_n,
  input wire push,
  input wire [`LRX_PC_W-1:0] push_addr,
  input wire pop,
  output reg [`LRX_PC_W-1:0] stack_top_entry
);
  reg [`LRX_PC_W-1:0] entry_r [0:`LRX_STACK_DEPTH-1];
  integer i;
  // ==========================================
  // shift stack
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `LRX_STACK_DEPTH; i = i + 1) begin
        entry_r[i] <= {`LRX_PC_W{1'b0}};
      end
      stack_top_entry <= {`LRX_PC_W{1'b0}};
    end else if (push) begin
      entry_r[0] <= push_addr;
      entry_r[1] <= entry_r[0];
      stack_top_entry <= push_addr;
    end else if (pop) begin
      // bottom entry repeats when popped past
      entry_r[0] <= entry_r[1];
      stack_top_entry <= entry_r[1];
    end
  end
endmodule // lrx_ret_stack

// [dv/lrx_chk.sv]
// lrx_chk.sv: port assertions for lrx_exec
// assumes: bound into lrx_exec, one clock domain
`timescale 1ns/1ps
module lrx_chk (
  input wire CLK_SYS, RST_N, INSTR_EN, FILE_WE, PC_LOAD, FLUSH,
  input wire [11:0] OPCODE,
  input wire [7:0] ACC, OPTION_REG, FILE_WDATA,
  input wire [4:0] FILE_ADDR,
  input wire [2:0] STATE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  wire tk = INSTR_EN && STATE == 3'h1;
  a_lit_load: assert property (tk && OPCODE[11:8] == 4'hC |=> ACC == $past(OPCODE[7:0]))
    else $error("literal load");
  a_opt_copy: assert property (tk && OPCODE == 12'h002 |=> OPTION_REG == $past(ACC))
    else $error("option copy");
  a_ret_first: assert property (tk && OPCODE[11:8] == 4'h8 |=> ACC == $past(OPCODE[7:0])
    && STATE == 3'h2 && !PC_LOAD) else $error("return first cycle");
  a_ret_flush: assert property (STATE == 3'h2 && INSTR_EN |=> PC_LOAD && FLUSH && STATE == 3'h1)
    else $error("return flush");
  a_pc_cause: assert property (PC_LOAD |-> $past(STATE) == 3'h2 && $past(INSTR_EN))
    else $error("pc load cause");
  a_file_store: assert property (tk && OPCODE[11:5] == 7'h01 |=> FILE_WE
    && FILE_ADDR == $past(OPCODE[4:0]) && FILE_WDATA == $past(ACC)) else $error("store");
endmodule // lrx_chk
bind lrx_exec lrx_chk u_chk (.*);

// [dv/lrx_exec_bench.sv]
// lrx_exec_bench.sv: self-checking bench for lrx_exec with a queue model
// assumes: lrx_exec and lrx_chk compiled before
`timescale 1ns/1ps
module lrx_exec_bench;
  reg CLK_SYS = 0, RST_N = 0, INSTR_EN = 0, CALL_PUSH = 0;
  reg [11:0] OPCODE = 0;
  reg [10:0] CALL_ADDR = 0, PC_IN = 0, pn = 11'h7ff;
  reg [7:0] acc = 0, opt = 8'hff, wd = 0;
  reg [4:0] fa = 0;
  wire [7:0] ACC, OPTION_REG, FILE_WDATA;
  wire FILE_WE, PC_LOAD, FLUSH;
  wire [4:0] FILE_ADDR;
  wire [10:0] PC_NEW;
  wire [2:0] STATE;
  integer err_total = 0, cmp_count = 0, cyc = 0, i, k;
  reg [10:0] stk[$];
  lrx_exec u_dut (.*);
  always #2 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    cyc = cyc + 1;
    if (cyc > 2000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  task chk(input string n, input [10:0] e, input [10:0] s);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        $display("ERROR %0s expected %h seen %h", n, e, s);
        err_total = err_total + 1;
      end
    end
  endtask
  task issue(input [11:0] op);
    begin
      @(posedge CLK_SYS) INSTR_EN <= 1;
      OPCODE <= op;
      PC_IN <= $urandom;
      @(posedge CLK_SYS) INSTR_EN <= 0;
      #1;
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    k = $urandom(32'ha6a1);
    repeat (5) @(posedge CLK_SYS);
    RST_N <= 1;
    for (i = 0; i < 40; i = i + 1) begin
      k = $urandom;
      case (k[9:8])
        0: issue({4'hC, k[7:0]});
        1: issue({7'h01, k[4:0]});
        2: issue(12'h002);
        default: issue(12'h000);
      endcase
      if (k[9:8] == 0) acc = k[7:0];
      if (k[9:8] == 1) wd = acc;
      if (k[9:8] == 1) fa = k[4:0];
      if (k[9:8] == 2) opt = acc;
      if (k[9:8] == 3) pn = PC_IN;
      chk("acc", acc, ACC);
      chk("option", opt, OPTION_REG);
      chk("we", k[9:8] == 1, FILE_WE);
      chk("wdata", wd, FILE_WDATA);
      chk("faddr", fa, FILE_ADDR);
      chk("pcnew", pn, PC_NEW);
      chk("pcload", 0, PC_LOAD | FLUSH);
    end
    $display("literal test done");
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge CLK_SYS) CALL_PUSH <= 1;
      CALL_ADDR <= $urandom;
      @(posedge CLK_SYS) CALL_PUSH <= 0;
      stk.push_back(CALL_ADDR);
    end
    for (i = 0; i < 2; i = i + 1) begin
      k = $urandom;
      issue({4'h8, k[7:0]});
      chk("ret acc", k[7:0], ACC);
      chk("state", 2, STATE);
      issue(12'h000);
      chk("flush", 1, PC_LOAD & FLUSH);
      chk("pc", stk.pop_back(), PC_NEW);
    end
    $display("return test done");
    complete_run;
  end
endmodule // lrx_exec_bench
